// >>> rtl/rss_cfg.svh
// Purpose: Constants for the rotate/set/halt/subtract execution block
// Assumes: 16-bit instruction words, 8-bit data, 25 MHz core clock
// Notes:   Register offsets are byte addresses on the AXI4-Lite slave
`ifndef RSS_CFG_SVH
`define RSS_CFG_SVH

`define RSS_OPC_ROT_MASK  16'hFC00
`define RSS_OPC_ROT_VAL   16'h4000
`define RSS_OPC_SET_MASK  16'hFE00
`define RSS_OPC_SET_VAL   16'h6800
`define RSS_OPC_SUB_MASK  16'hFC00
`define RSS_OPC_SUB_VAL   16'h5400
`define RSS_OPC_HALT      16'h0003
`define RSS_BIT_D         9
`define RSS_BIT_A         8
`define RSS_ILO_MAX       8'h5F
`define RSS_ACC_SFR_BASE  8'h60
`define RSS_SFR_BANK      4'hF
`define RSS_ALL_ONES      8'hFF
`define RSS_PHASES        2'h3
`define RSS_WDT_POST_W    8

`define RSS_ADDR_CTRL     4'h0
`define RSS_ADDR_INSTR    4'h4
`define RSS_ADDR_STAT     4'h8
`define RSS_ADDR_IRQ      4'hC
`define RSS_ADDR_MASK     5'h10
`define RSS_ADDR_WREG     5'h14
`define RSS_ADDR_FLAGS    5'h18
`define RSS_ADDR_WAKE     5'h1C

`define RSS_EV_DONE       0
`define RSS_EV_HALT       1
`define RSS_EV_WAKE       2
`define RSS_EV_W          3

`define RSS_RESP_OK       2'h0
`define RSS_RESP_SLVERR   2'h2

`endif

// >>> rtl/rss_pkg.sv
// Purpose: Types for the rotate/set/halt/subtract execution block
// Assumes: Constants come from rss_cfg.svh
// Notes:   Types only
package rss_pkg;

  typedef enum logic [1:0] {
    RSS_PH_DECODE,
    RSS_PH_READ,
    RSS_PH_PROC,
    RSS_PH_WRITE
  } rss_phase_t;

  typedef enum logic [2:0] {
    RSS_OP_NONE,
    RSS_OP_ROT,
    RSS_OP_SET,
    RSS_OP_SUB,
    RSS_OP_HALT
  } rss_op_t;

  typedef struct packed {
    logic       n;
    logic       z;
    logic       c;
    logic       time_out_flag;
    logic       power_down_flag;
  } rss_flags_t;

  typedef struct packed {
    logic       we;
    logic [3:0] bank;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rss_mem_req_t;

  typedef struct packed {
    rss_op_t    op;
    logic       dest_f;
    logic [3:0] bank;
    logic [7:0] addr;
  } rss_dec_t;

endpackage

// >>> rtl/rss_decode.sv
// Purpose: Instruction decode and operand address forming
// Assumes: Instruction word stable during the decode phase
// Notes:   Pure combinational, registered by the core
`timescale 1ns/1ps
`include "rss_cfg.svh"
module rss_decode (
  // Instruction
  input  wire logic [15:0]     instr,
  // Addressing context
  input  wire logic [3:0]      bank_select_reg,
  input  wire logic            ext_set_en,
  input  wire logic [7:0]      fsr2_base,
  // Result
  output rss_pkg::rss_dec_t    dec
);

  logic [7:0] f;
  logic       a;

  always_comb begin
    f           = instr[7:0];
    a           = instr[`RSS_BIT_A];
    dec.op      = rss_pkg::RSS_OP_NONE;
    dec.dest_f  = instr[`RSS_BIT_D];
    if ((instr & `RSS_OPC_ROT_MASK) == `RSS_OPC_ROT_VAL) begin
      dec.op = rss_pkg::RSS_OP_ROT;
    end else if ((instr & `RSS_OPC_SET_MASK) == `RSS_OPC_SET_VAL) begin
      dec.op     = rss_pkg::RSS_OP_SET;
      dec.dest_f = 1'b1;
    end else if ((instr & `RSS_OPC_SUB_MASK) == `RSS_OPC_SUB_VAL) begin
      dec.op = rss_pkg::RSS_OP_SUB;
    end else if (instr == `RSS_OPC_HALT) begin
      dec.op = rss_pkg::RSS_OP_HALT;
    end
    if (a) begin
      dec.bank = bank_select_reg;
      dec.addr = f;
    end else if (ext_set_en && f <= `RSS_ILO_MAX) begin
      // Indexed literal offset: base pointer plus literal, bank 0 window
      dec.bank = 4'h0;
      dec.addr = 8'(fsr2_base + f);
    end else begin
      // Access bank: offsets below 0x60 bank 0, 0x60 and above special registers
      dec.bank = (f >= `RSS_ACC_SFR_BASE) ? `RSS_SFR_BANK : 4'h0;
      dec.addr = f;
    end
  end

endmodule // rss_decode

// >>> rtl/rss_alu.sv
// Purpose: Result and flag computation for rotate, set and subtract
// Assumes: Operand read already complete
// Notes:   Combinational
`timescale 1ns/1ps
`include "rss_cfg.svh"
module rss_alu (
  // Operands
  input  rss_pkg::rss_op_t     op,
  input  wire logic [7:0]      fval,
  input  wire logic [7:0]      wval,
  input  wire logic            c_in,
  // Result
  output logic [7:0]           res,
  output logic                 upd_nz,
  output logic                 upd_c,
  output logic                 c_out
);

  logic [8:0] diff;

  always_comb begin
    diff   = {1'b0, wval} - {1'b0, fval} - {8'h00, ~c_in};
    res    = fval;
    upd_nz = 1'b0;
    upd_c  = 1'b0;
    c_out  = c_in;
    case (op)
      rss_pkg::RSS_OP_ROT: begin
        res    = {fval[0], fval[7:1]};
        upd_nz = 1'b1;
      end
      rss_pkg::RSS_OP_SET: begin
        res = `RSS_ALL_ONES;
      end
      rss_pkg::RSS_OP_SUB: begin
        res    = diff[7:0];
        upd_nz = 1'b1;
        upd_c  = 1'b1;
        c_out  = ~diff[8]; // Carry high means no borrow
      end
      default: begin
        res = fval;
      end
    endcase
  end

endmodule // rss_alu

// >>> rtl/rss_core.sv
// Purpose: Execution of rotate, set, halt and subtract with AXI4-Lite control
// Assumes: Single clock, synchronous active-high reset, one request in flight
// Notes:   Data memory is an external port answering the cycle after its read strobe
`timescale 1ns/1ps
`include "rss_cfg.svh"
module rss_core (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // AXI4-Lite write address, data and response
  input  wire logic [31:0]       s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read
  input  wire logic [31:0]       s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Data memory
  output rss_pkg::rss_mem_req_t  mem_req,
  output logic                   mem_en,
  input  wire logic [7:0]        mem_rdata,
  // Power control
  output logic                   osc_stop,
  output logic                   wdt_clear,
  input  wire logic              wdt_expire_pin,
  input  wire logic              wake_pin,
  // Interrupt
  output logic                   irq
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic                awready;
    logic                wready;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                aw_hold;
    logic                w_hold;
    logic [4:0]          aw_addr;
    logic [31:0]         w_data;
    logic [3:0]          w_strb;
    logic                arready;
    logic                rvalid;
    logic [31:0]         rdata;
    logic [1:0]          rresp;
    logic [15:0]         instr;
    logic [3:0]          bank_select_reg;
    logic                ext_set_en;
    logic [7:0]          fsr2_base;
    logic [7:0]          wreg;
    rss_pkg::rss_flags_t flags;
    logic                busy;
    rss_pkg::rss_phase_t phase;
    rss_pkg::rss_dec_t   dec;
    logic [7:0]          fval;
    logic                halted;
    logic [3:0]          irq_stat;
    logic [3:0]          irq_mask;
    logic                irq;
    rss_pkg::rss_mem_req_t mem;
    logic                mem_en;
    logic                osc_stop;
    logic                wdt_clear;
    logic [1:0]          wdt_sync;
    logic [1:0]          wake_sync;
  } rss_state_t;

  rss_state_t        s_reg;
  rss_state_t        s_next;
  rss_pkg::rss_dec_t dec_w;
  logic [7:0]        alu_res;
  logic              alu_nz;
  logic              alu_c;
  logic              alu_cout;

  rss_decode u_decode (
    .instr           (s_reg.instr),
    .bank_select_reg (s_reg.bank_select_reg),
    .ext_set_en      (s_reg.ext_set_en),
    .fsr2_base       (s_reg.fsr2_base),
    .dec             (dec_w)
  );

  rss_alu u_alu (
    .op     (s_reg.dec.op),
    .fval   (s_reg.fval),
    .wval   (s_reg.wreg),
    .c_in   (s_reg.flags.c),
    .res    (alu_res),
    .upd_nz (alu_nz),
    .upd_c  (alu_c),
    .c_out  (alu_cout)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  logic [3:0] ev;
  logic       wr_go;
  logic       wdt_wake;
  logic       any_wake;

  always_comb begin
    s_next = s_reg;
    ev     = 4'h0;
    s_next.wdt_sync  = {s_reg.wdt_sync[0], wdt_expire_pin};
    s_next.wake_sync = {s_reg.wake_sync[0], wake_pin};
    wdt_wake = s_reg.wdt_sync[1];
    any_wake = s_reg.wdt_sync[1] | s_reg.wake_sync[1];
    s_next.mem_en    = 1'b0;
    s_next.mem.we    = 1'b0;
    s_next.wdt_clear = 1'b0;

    // Write channel: address and data taken in either order
    if (s_reg.awready && s_axi_awvalid) begin
      s_next.awready = 1'b0;
      s_next.aw_hold = 1'b1;
      s_next.aw_addr = s_axi_awaddr[4:0];
    end
    if (s_reg.wready && s_axi_wvalid) begin
      s_next.wready = 1'b0;
      s_next.w_hold = 1'b1;
      s_next.w_data = s_axi_wdata;
      s_next.w_strb = s_axi_wstrb;
    end
    wr_go = s_reg.aw_hold && s_reg.w_hold && !s_reg.bvalid;
    if (wr_go) begin
      s_next.aw_hold = 1'b0;
      s_next.w_hold  = 1'b0;
      s_next.bvalid  = 1'b1;
      s_next.bresp   = `RSS_RESP_OK;
      case (s_reg.aw_addr)
        5'(`RSS_ADDR_CTRL): begin
          if (s_reg.w_strb[0]) begin
            s_next.bank_select_reg = s_reg.w_data[3:0];
            s_next.ext_set_en      = s_reg.w_data[4];
          end
          if (s_reg.w_strb[1]) begin
            s_next.fsr2_base = s_reg.w_data[15:8];
          end
        end
        5'(`RSS_ADDR_INSTR): begin
          // A new instruction is ignored while one runs or the core is halted
          if (!s_reg.busy && !s_reg.halted && (&s_reg.w_strb[1:0])) begin
            s_next.instr = s_reg.w_data[15:0];
            s_next.busy  = 1'b1;
            s_next.phase = rss_pkg::RSS_PH_DECODE;
          end
        end
        5'(`RSS_ADDR_IRQ): begin
          if (s_reg.w_strb[0]) begin
            s_next.irq_stat = s_reg.irq_stat & ~s_reg.w_data[3:0];
          end
        end
        `RSS_ADDR_MASK: begin
          if (s_reg.w_strb[0]) begin
            s_next.irq_mask = s_reg.w_data[3:0];
          end
        end
        `RSS_ADDR_WREG: begin
          if (s_reg.w_strb[0]) begin
            s_next.wreg = s_reg.w_data[7:0];
          end
        end
        `RSS_ADDR_FLAGS: begin
          if (s_reg.w_strb[0]) begin
            s_next.flags.c = s_reg.w_data[2];
          end
        end
        default: begin
          s_next.bresp = `RSS_RESP_SLVERR;
        end
      endcase
    end
    if (s_reg.bvalid && s_axi_bready) begin
      s_next.bvalid  = 1'b0;
      s_next.awready = 1'b1;
      s_next.wready  = 1'b1;
    end

    // Read channel
    if (s_reg.arready && s_axi_arvalid) begin
      s_next.arready = 1'b0;
      s_next.rvalid  = 1'b1;
      s_next.rresp   = `RSS_RESP_OK;
      s_next.rdata   = 32'h0000_0000;
      case (s_axi_araddr[4:0])
        5'(`RSS_ADDR_CTRL): s_next.rdata = {16'h0000, s_reg.fsr2_base, 3'h0,
                                            s_reg.ext_set_en, s_reg.bank_select_reg};
        5'(`RSS_ADDR_INSTR): s_next.rdata = {16'h0000, s_reg.instr};
        5'(`RSS_ADDR_STAT): s_next.rdata = {28'h0000000, s_reg.osc_stop,
                                            s_reg.halted, s_reg.busy, 1'b0};
        5'(`RSS_ADDR_IRQ): s_next.rdata = {28'h0000000, s_reg.irq_stat};
        `RSS_ADDR_MASK: s_next.rdata = {28'h0000000, s_reg.irq_mask};
        `RSS_ADDR_WREG: s_next.rdata = {24'h000000, s_reg.wreg};
        `RSS_ADDR_FLAGS: s_next.rdata = {27'h0000000, s_reg.flags};
        default: s_next.rresp = `RSS_RESP_SLVERR;
      endcase
    end
    if (s_reg.rvalid && s_axi_rready) begin
      s_next.rvalid  = 1'b0;
      s_next.arready = 1'b1;
    end

    // Four-phase instruction cycle
    if (s_reg.busy) begin
      case (s_reg.phase)
        rss_pkg::RSS_PH_DECODE: begin
          s_next.dec   = dec_w;
          s_next.phase = rss_pkg::RSS_PH_READ;
          if (dec_w.op != rss_pkg::RSS_OP_HALT && dec_w.op != rss_pkg::RSS_OP_NONE) begin
            s_next.mem_en    = 1'b1;
            s_next.mem.bank  = dec_w.bank;
            s_next.mem.addr  = dec_w.addr;
          end
        end
        rss_pkg::RSS_PH_READ: begin
          // Registered memory: its data only stands once the strobe has been taken
          s_next.phase = rss_pkg::RSS_PH_PROC;
        end
        rss_pkg::RSS_PH_PROC: begin
          s_next.fval  = mem_rdata;
          s_next.phase = rss_pkg::RSS_PH_WRITE;
        end
        rss_pkg::RSS_PH_WRITE: begin
          s_next.busy  = 1'b0;
          s_next.phase = rss_pkg::RSS_PH_DECODE;
          ev[`RSS_EV_DONE] = 1'b1;
          if (s_reg.dec.op == rss_pkg::RSS_OP_HALT) begin
            s_next.flags.power_down_flag = 1'b0;
            s_next.flags.time_out_flag   = 1'b1;
            s_next.wdt_clear = 1'b1;
            s_next.halted    = 1'b1;
            s_next.osc_stop  = 1'b1;
            ev[`RSS_EV_HALT] = 1'b1;
          end else if (s_reg.dec.op != rss_pkg::RSS_OP_NONE) begin
            if (s_reg.dec.dest_f) begin
              s_next.mem_en    = 1'b1;
              s_next.mem.we    = 1'b1;
              s_next.mem.wdata = alu_res;
            end else begin
              s_next.wreg = alu_res;
              ev[`RSS_EV_W] = 1'b1;
            end
            if (alu_nz) begin
              s_next.flags.n = alu_res[7];
              s_next.flags.z = (alu_res == 8'h00);
            end
            if (alu_c) begin
              s_next.flags.c = alu_cout;
            end
          end
        end
        default: s_next.phase = rss_pkg::RSS_PH_DECODE;
      endcase
    end

    // Wake from halt
    if (s_reg.halted && any_wake) begin
      s_next.halted   = 1'b0;
      s_next.osc_stop = 1'b0;
      ev[`RSS_EV_WAKE] = 1'b1;
      if (wdt_wake) begin
        s_next.flags.time_out_flag = 1'b0;
      end
    end

    // Set wins over a clear written in the same cycle
    s_next.irq_stat = s_next.irq_stat | ev;
    s_next.irq      = |(s_next.irq_stat & s_next.irq_mask);

    if (rst) begin
      s_next = '0;
      s_next.awready = 1'b1;
      s_next.wready  = 1'b1;
      s_next.arready = 1'b1;
      s_next.flags.time_out_flag   = 1'b1;
      s_next.flags.power_down_flag = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    s_reg <= s_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign s_axi_awready = s_reg.awready;
  assign s_axi_wready  = s_reg.wready;
  assign s_axi_bvalid  = s_reg.bvalid;
  assign s_axi_bresp   = s_reg.bresp;
  assign s_axi_arready = s_reg.arready;
  assign s_axi_rvalid  = s_reg.rvalid;
  assign s_axi_rdata   = s_reg.rdata;
  assign s_axi_rresp   = s_reg.rresp;
  assign mem_req       = s_reg.mem;
  assign mem_en        = s_reg.mem_en;
  assign osc_stop      = s_reg.osc_stop;
  assign wdt_clear     = s_reg.wdt_clear;
  assign irq           = s_reg.irq;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  a_rot_result: assert property (@(posedge clk) disable iff (rst)
    s_reg.busy && s_reg.phase == rss_pkg::RSS_PH_WRITE
      && s_reg.dec.op == rss_pkg::RSS_OP_ROT && s_reg.dec.dest_f
    |=> mem_req.wdata == {$past(s_reg.fval[0]), $past(s_reg.fval[7:1])})
    else $error("rotate result wrong");

  a_dest_w_keep: assert property (@(posedge clk) disable iff (rst)
    s_reg.busy && s_reg.phase == rss_pkg::RSS_PH_WRITE && !s_reg.dec.dest_f
      && s_reg.dec.op == rss_pkg::RSS_OP_ROT
    |=> !mem_en && s_reg.wreg == {$past(s_reg.fval[0]), $past(s_reg.fval[7:1])})
    else $error("destination w mishandled");

  a_set_flags: assert property (@(posedge clk) disable iff (rst)
    s_reg.busy && s_reg.phase == rss_pkg::RSS_PH_WRITE
      && s_reg.dec.op == rss_pkg::RSS_OP_SET
    |=> mem_en && mem_req.we && mem_req.wdata == `RSS_ALL_ONES && $stable(s_reg.flags))
    else $error("set op wrong");

  a_halt_flags: assert property (@(posedge clk) disable iff (rst)
    s_reg.busy && s_reg.phase == rss_pkg::RSS_PH_WRITE
      && s_reg.dec.op == rss_pkg::RSS_OP_HALT
    |=> !s_reg.flags.power_down_flag && wdt_clear && osc_stop)
    else $error("halt side effects wrong");

  a_halt_to: assert property (@(posedge clk) disable iff (rst)
    s_reg.busy && s_reg.phase == rss_pkg::RSS_PH_WRITE
      && s_reg.dec.op == rss_pkg::RSS_OP_HALT && !any_wake
    |=> s_reg.flags.time_out_flag && s_reg.halted)
    else $error("time-out flag not set");

  a_wdt_wake_to: assert property (@(posedge clk) disable iff (rst)
    s_reg.halted && s_reg.wdt_sync[1] |=> !s_reg.flags.time_out_flag && !osc_stop)
    else $error("watchdog wake kept time-out");

  a_sub_carry: assert property (@(posedge clk) disable iff (rst)
    s_reg.busy && s_reg.phase == rss_pkg::RSS_PH_WRITE
      && s_reg.dec.op == rss_pkg::RSS_OP_SUB
    |=> s_reg.flags.c == ($past(s_reg.wreg) >= 9'($past(s_reg.fval)) + 9'(!$past(s_reg.flags.c))))
    else $error("subtract carry wrong");

  a_four_phase: assert property (@(posedge clk) disable iff (rst)
    $rose(s_reg.busy) |-> s_reg.busy [*4] ##1 !s_reg.busy)
    else $error("instruction not four phases");

  a_bank_sel: assert property (@(posedge clk) disable iff (rst)
    s_reg.busy && s_reg.phase == rss_pkg::RSS_PH_DECODE && s_reg.instr[`RSS_BIT_A]
      && dec_w.op != rss_pkg::RSS_OP_NONE && dec_w.op != rss_pkg::RSS_OP_HALT
    |=> mem_req.bank == $past(s_reg.bank_select_reg))
    else $error("bank select ignored");

  c_rot: cover property (@(posedge clk) s_reg.dec.op == rss_pkg::RSS_OP_ROT && ev[`RSS_EV_DONE]);
  c_sub: cover property (@(posedge clk) s_reg.dec.op == rss_pkg::RSS_OP_SUB && ev[`RSS_EV_DONE]);
  c_halt_wake: cover property (@(posedge clk) s_reg.halted ##[1:50] !s_reg.halted);

endmodule // rss_core

// >>> tb/rss_core_tb.sv
// Purpose: Self-checking bench for rss_core over AXI4-Lite and its memory port
// Assumes: Read data due the cycle after a read strobe; results land within 8 cycles
// Notes:   Expected results queue up and a falling-edge watcher compares them
`timescale 1ns/1ps
`include "rss_cfg.svh"
`define CHK(nm, e, s) begin checks_done++; if ((e) !== (s)) begin err_total++; \
  $display("mismatch %s expected %h seen %h", nm, e, s); end end
module rotate_set_sleep_subtract_exec_tb;
  logic                  clk = 0;
  logic                  rst = 1;
  logic [31:0]           awaddr = 0, wdata = 0, araddr = 0, rdata;
  logic                  awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
  logic                  awready, wready, bvalid, arready, rvalid;
  logic [1:0]            bresp, rresp;
  rss_pkg::rss_mem_req_t mem_req;
  logic                  mem_en, osc_stop, wdt_clear, irq;
  logic [7:0]            mem_rdata = 8'h00;
  logic                  wdt_pin = 0, wake_pin = 0;
  logic [7:0]            mem [16][256];
  logic [33:0]           rq[$];
  logic [1:0]            bq[$];
  logic [19:0]           mq[$];
  logic                  fn = 0, fz = 0, fc = 0, fto = 1, fpd = 1;
  int                    err_total = 0, checks_done = 0, wdt_pulses = 0, seed = 30;

  always #20 clk = ~clk;

  rss_core u_rss_core (
    .clk(clk), .rst(rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .mem_req(mem_req), .mem_en(mem_en), .mem_rdata(mem_rdata),
    .osc_stop(osc_stop), .wdt_clear(wdt_clear), .wdt_expire_pin(wdt_pin),
    .wake_pin(wake_pin), .irq(irq)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Data memory: outside a read the bus toggles so stale data cannot pass
  always @(posedge clk) begin
    if (mem_en && !mem_req.we) begin
      mem_rdata <= mem[mem_req.bank][mem_req.addr];
    end else begin
      mem_rdata <= ~mem_rdata;
    end
    if (mem_en && mem_req.we) begin
      mem[mem_req.bank][mem_req.addr] <= mem_req.wdata;
    end
  end

  // Watcher: the falling edge sees settled outputs ahead of each handshake
  always @(negedge clk) begin
    logic [33:0] er;
    logic [19:0] em;
    logic [1:0]  eb;
    if (!rst) begin
      if (rvalid && rready) begin
        er = rq.size() ? rq.pop_front() : 'x;
        `CHK("read", er, {rresp, rdata})
      end
      if (bvalid && bready) begin
        eb = bq.size() ? bq.pop_front() : 'x;
        `CHK("bresp", eb, bresp)
      end
      if (mem_en && mem_req.we) begin
        em = mq.size() ? mq.pop_front() : 'x;
        `CHK("mem write", em, {mem_req.bank, mem_req.addr, mem_req.wdata})
      end
      if (wdt_clear === 1'b1) wdt_pulses++;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d,
                    input logic [1:0] r = `RSS_RESP_OK);
    bit ta, tw, tb;
    // Let an edge pass so the previous release and this request never share a step
    @(posedge clk);
    bq.push_back(r);
    awaddr <= a;
    wdata <= d;
    {awv, wv, bready} <= 3'b111;
    tb = 0;
    for (int n = 0; n < 40 && !tb; n++) begin
      @(negedge clk);
      ta = awv && awready;
      tw = wv && wready;
      tb = bready && bvalid;
      @(posedge clk);
      {awv, wv, bready} <= {awv && !ta, wv && !tw, bready && !tb};
    end
    if (!tb) begin
      err_total++;
      end_of_test();
    end
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    bit ta, tb;
    @(posedge clk);
    rq.push_back({2'h0, e});
    araddr <= a;
    {arv, rready} <= 2'b11;
    tb = 0;
    for (int n = 0; n < 40 && !tb; n++) begin
      @(negedge clk);
      ta = arv && arready;
      tb = rready && rvalid;
      @(posedge clk);
      {arv, rready} <= {arv && !ta, rready && !tb};
    end
    if (!tb) begin
      err_total++;
      end_of_test();
    end
  endtask

  task automatic exec(input logic [15:0] i);
    wr(`RSS_ADDR_INSTR, {16'h0, i});
    repeat (8) @(posedge clk);
  endtask

  function automatic logic [31:0] flags();
    return {27'h0, fn, fz, fc, fto, fpd};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] ctl [6] = '{32'h5, 32'h5, 32'h1010, 32'h1010, 32'h1010, 32'h1015};
    logic [7:0]  sf  [6] = '{8'h33, 8'h80, 8'h05, 8'h5F, 8'h60, 8'h05};
    logic [11:0] sx  [6] = '{12'h533, 12'hF80, 12'h015, 12'h06F, 12'hF60, 12'h505};
    logic [5:0]  sa = 6'b100001;
    logic [7:0]  v, f, r, w;
    logic [8:0]  diff;
    logic [3:0]  bk;
    repeat (16) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    rd(`RSS_ADDR_FLAGS, flags());
    wr(32'h2, 32'h0, `RSS_RESP_SLVERR);
    $display("test reset and map done");

    wr(`RSS_ADDR_CTRL, 32'h5);
    for (int j = 0; j < 2; j++) begin
      v = j ? 8'($random(seed)) : 8'hD7;
      f = j ? 8'h33 : 8'h20;
      bk = j ? 4'h5 : 4'h0;
      mem[bk][f] = v;
      r = {v[0], v[7:1]};
      {fn, fz} = {r[7], r == 8'h00};
      if (j == 0) mq.push_back({4'h0, f, r});
      exec({6'b010000, j == 0, j == 1, f});
      if (j) rd(`RSS_ADDR_WREG, {24'h0, r});
      rd(`RSS_ADDR_FLAGS, flags());
    end
    $display("test rotate done");

    for (int i = 0; i < 6; i++) begin
      wr(`RSS_ADDR_CTRL, ctl[i]);
      mq.push_back({sx[i], `RSS_ALL_ONES});
      exec({7'b0110100, sa[i], sf[i]});
    end
    rd(`RSS_ADDR_FLAGS, flags());
    wr(`RSS_ADDR_CTRL, 32'h0);
    $display("test set done");

    for (int j = 0; j < 4; j++) begin
      w = (j == 0) ? 8'h02 : 8'($random(seed));
      v = (j == 0) ? 8'h03 : 8'($random(seed));
      fc = (j == 0) ? 1'b1 : 1'($random(seed));
      mem[0][8'h40] = v;
      wr(`RSS_ADDR_WREG, {24'h0, w});
      wr(`RSS_ADDR_FLAGS, {29'h0, fc, 2'h0});
      diff = {1'b0, w} - {1'b0, v} - {8'h0, !fc};
      r = diff[7:0];
      {fn, fz, fc} = {r[7], r == 8'h00, !diff[8]};
      if (j[0] == 1'b0) mq.push_back({4'h0, 8'h40, r});
      exec({6'b010101, j[0] == 1'b0, 1'b0, 8'h40});
      rd(`RSS_ADDR_WREG, {24'h0, j[0] ? r : w});
      rd(`RSS_ADDR_FLAGS, flags());
    end
    $display("test subtract done");

    // Pin wake keeps the time-out flag; only a watchdog wake clears it
    wr(`RSS_ADDR_MASK, 32'h2);
    for (int k = 0; k < 2; k++) begin
      exec(`RSS_OPC_HALT);
      {fto, fpd} = 2'b10;
      `CHK("osc_stop", 1'b1, osc_stop)
      `CHK("irq", 1'b1, irq)
      rd(`RSS_ADDR_STAT, 32'hC);
      rd(`RSS_ADDR_FLAGS, flags());
      wr(`RSS_ADDR_IRQ, 32'h2);
      repeat (3) @(posedge clk);
      `CHK("irq", 1'b0, irq)
      if (k == 0) wdt_pin <= 1'b1;
      else wake_pin <= 1'b1;
      for (int n = 0; n < 20 && osc_stop !== 1'b0; n++) @(posedge clk);
      `CHK("osc_stop", 1'b0, osc_stop)
      if (osc_stop !== 1'b0) end_of_test();
      {wdt_pin, wake_pin} <= 2'b00;
      fto = (k == 1);
      rd(`RSS_ADDR_FLAGS, flags());
    end
    `CHK("wdt_clear pulses", 2, wdt_pulses)
    $display("test halt done");
    repeat (4) @(posedge clk);
    `CHK("queues empty", 0, rq.size() + bq.size() + mq.size())
    end_of_test();
  end
endmodule // rotate_set_sleep_subtract_exec_tb
